/* bench/acr_ctrl_properties.sv */
`timescale 1ns/1ps
module acr_ctrl_properties (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  rdata,
  input wire logic        timer_compare_evt,
  input wire logic [1:0]  reference_choice_field,
  input wire logic        conv_active,
  input wire logic [15:0] random_value
);
  // Mirror of the trigger source, updated as the register is
  logic [1:0] src_q;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      src_q <= 2'h3;
    else if (wr_stb && addr == 8'hB4)
      src_q <= wdata[5:4];
  // Busy age; shortest sequence is 480 cycles, so early writes miss its end
  logic [9:0] act_q;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      act_q <= 10'h000;
    else if (!conv_active)
      act_q <= 10'h000;
    else if (act_q != 10'h3FF)
      act_q <= act_q + 10'h001;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence c1_wr;
    wr_stb && addr == 8'hB4;
  endsequence
  a_rdata_idle: assert property (
    !$past(rd_stb) |-> rdata == 8'h00) else $error("rdata not zero");
  a_low_nibble: assert property (
    $past(rd_stb) && $past(addr) == 8'hBA |-> rdata[3:0] == 4'h0)
    else $error("low nibble not zero");
  a_go_start: assert property (
    c1_wr ##0 (wdata[6] && wdata[5:4] == 2'h3 && !conv_active)
    |=> ##1 conv_active) else $error("go did not start");
  a_no_stray: assert property (
    src_q == 2'h3 && !conv_active && !wr_stb && !$past(wr_stb)
    |=> !conv_active) else $error("start without go");
  a_go_zero: assert property (
    c1_wr ##0 (!wdata[6] && conv_active && act_q < 10'h190)
    |=> conv_active) else $error("go zero aborted");
  a_timer_start: assert property (
    src_q == 2'h2 && timer_compare_evt && !conv_active && !wr_stb
    |-> ##[1:2] conv_active) else $error("timer did not start");
  a_full_speed: assert property (
    src_q == 2'h1 && $fell(conv_active) |-> ##[1:2] conv_active)
    else $error("no back to back restart");
  a_ref_copy: assert property (
    wr_stb && addr == 8'hB5 |=> reference_choice_field == $past(wdata[7:6]))
    else $error("reference field wrong");
  a_rnd_step: assert property (
    c1_wr ##0 wdata[3:2] == 2'h1
    |=> ##1 random_value != $past(random_value))
    else $error("random value not stepped");
  a_rnd_hold: assert property (
    !$past(wr_stb && addr == 8'hB4 && wdata[3:2] == 2'h1)
    |=> $stable(random_value)) else $error("random value moved");
endmodule // acr_ctrl_properties
bind acr_ctrl acr_ctrl_properties acr_ctrl_properties_inst (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .timer_compare_evt(timer_compare_evt),
  .reference_choice_field(reference_choice_field),
  .conv_active(conv_active), .random_value(random_value));

/* bench/acr_ctrl_tb_top.sv */
`timescale 1ns/1ps
module acr_ctrl_tb_top;
  logic        mclk, rst_n, wr_stb, rd_stb, pin_req, tmr_req, pend, ext, tmr;
  logic        busy;
  logic [7:0]  addr, wdata, rdata;
  logic [11:0] smp, msmp, res;
  logic [3:0]  seq_end, mux;
  logic [1:0]  refc;
  logic [15:0] rnd, r0;
  int          num_errors, checks, cyc, len, dur;
  logic [7:0]  exp_q[$];
  acr_ctrl acr_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .external_trigger_pin(ext), .timer_compare_evt(tmr),
    .modulator_sample(msmp), .sequence_end_field(seq_end),
    .reference_choice_field(refc), .mux_channel(mux),
    .conv_active(busy), .random_value(rnd));
  acr_far_model acr_far_model_inst (.mclk(mclk), .pin_req(pin_req),
    .tmr_req(tmr_req), .next_sample(smp), .external_trigger_pin(ext),
    .timer_compare_evt(tmr), .modulator_sample(msmp));
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd_stb <= 1'b0;
  endtask
  // Waits a few cycles for a start, then times the busy span
  task automatic meas();
    len = 0;
    repeat (8) if (busy !== 1'b1) @(posedge mclk);
    while (busy === 1'b1 && len < 4000)
    begin
      @(posedge mclk);
      len++;
    end
  endtask
  always @(posedge mclk)
  begin
    if (pend)
      chk("rdata", rdata, exp_q.pop_front());
    pend <= rd_stb;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  initial
  begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    {rst_n, wr_stb, rd_stb, pin_req, tmr_req, pend, addr, wdata} = '0;
    {smp, seq_end, cyc} = '0;
    void'($urandom(32'h43545F6A));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'hB4, 8'h33);
    rd(8'hB5, 8'h10);
    rd(8'hBB, 8'h00);
    rd(8'h00, 8'h00);
    for (int d = 0; d < 4; d++)
    begin
      smp <= 12'($urandom);
      dur = ((64 << d) + 16) * 6;
      wr(8'hB5, {2'(d), 2'(d), 4'h0});
      // low bits always written as 11
      wr(8'hB4, 8'h73);
      rd(8'hB4, 8'h73);
      wr(8'hB4, 8'h33);
      meas();
      chk("length", 8'(len >= dur - 16 && len <= dur + 6), 8'h01);
      res = smp & (12'hFFF << (d == 0 ? 5 : d == 1 ? 3 : d == 2 ? 2 : 0));
      rd(8'hB4, 8'hB3);
      rd(8'hB5, {2'(d), 2'(d), 4'h0});
      rd(8'hBA, {res[3:0], 4'h0});
      rd(8'hBB, res[11:4]);
      rd(8'hB4, 8'h33);
    end
    wr(8'hB4, 8'h43);
    rd(8'hB4, 8'h03);
    pin_req <= 1'b1;
    meas();
    pin_req <= 1'b0;
    rd(8'hB4, 8'h83);
    rd(8'hBB, smp[11:4]);
    wr(8'hB4, 8'h23);
    tmr_req <= 1'b1;
    @(posedge mclk);
    tmr_req <= 1'b0;
    meas();
    rd(8'hB4, 8'hA3);
    wr(8'hB5, 8'h00);
    wr(8'hB4, 8'h13);
    meas();
    meas();
    chk("restart", 8'(len > 0), 8'h01);
    wr(8'hB4, 8'h33);
    meas();
    rd(8'hB4, 8'hB3);
    rd(8'hBB, smp[11:4] & 8'hFE);
    seq_end <= 4'h9;
    wr(8'hB4, 8'h73);
    meas();
    chk("mux", 8'(mux), 8'h09);
    chk("pairs", 8'(len > 900), 8'h01);
    rd(8'hB5, 8'h09);
    rd(8'hBB, smp[11:4] & 8'hFE);
    r0 = rnd;
    wr(8'hB4, 8'h37);
    rd(8'hB4, 8'h33);
    chk("random", 8'(rnd != r0), 8'h01);
    repeat (3) @(posedge mclk);
    end_of_test();
  end
endmodule // acr_ctrl_tb_top

/* bench/acr_far_model.sv */
`timescale 1ns/1ps
module acr_far_model (
  input  wire logic        mclk,
  input  wire logic        pin_req,
  input  wire logic        tmr_req,
  input  wire logic [11:0] next_sample,
  output logic             external_trigger_pin,
  output logic             timer_compare_evt,
  output logic      [11:0] modulator_sample
);
  always_ff @(posedge mclk)
  begin
    external_trigger_pin <= pin_req;
    timer_compare_evt    <= tmr_req && !timer_compare_evt;
    modulator_sample     <= next_sample;
  end
endmodule // acr_far_model

/* rtl/acr_ctrl.sv */
// What this block does
// RULE1: low result: four LSBs high, zeros low
// RULE2: high result holds eight result MSBs
// RULE3: valid bits depend on decimation rate
// RULE4: done sets at end, clears on high read
// RULE5: second completion just keeps done set
// RULE6: go reads one until sequence finishes
// RULE7: go starts only with source 11, idle
// RULE8: source 00 pin, 10 timer, 11 go
// RULE9: source 01 runs sequences back to back
// RULE10: random field 01 steps LFSR thirteen times
// RULE11: random field returns to 00 when done
// RULE12: software writes 11 to low bits
// RULE13: reference field selects sequence reference
// RULE14: decimation field sets resolution and duration
// RULE15: codes 00,01 give 64/7 and 128/9
// RULE16: codes 10,11 give 256/10 and 512/12
// RULE17: differential ends start at first pair
// RULE18: conversion lasts rate plus sixteen ADC clocks
// RULE19: pin trigger starts on rising edge
// RULE20: writing go zero does not abort
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "acr_params.svh"
module acr_ctrl #(
  parameter int CHAN_BITS = 3
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  input  wire logic        external_trigger_pin,
  input  wire logic        timer_compare_evt,
  input  wire logic [11:0] modulator_sample,
  input  wire logic [3:0]  sequence_end_field,
  output logic      [1:0]  reference_choice_field,
  output logic      [3:0]  mux_channel,
  output logic             conv_active,
  output logic      [15:0] random_value
);
  acr_pkg::acr_bus_s     bus;
  acr_pkg::acr_state_e   st_q, st_d;
  logic [1:0]  trig_q, trig_d, rnd_q, rnd_d, low_q, low_d;
  logic [1:0]  ref_q, ref_d, dec_q, dec_d;
  logic        done_q, done_d, go_q, go_d, pin_q;
  logic [11:0] res_q, res_d;
  logic [15:0] lfsr_q, lfsr_d;
  logic [2:0]  div_q, div_d;
  logic [9:0]  cnt_q, cnt_d;
  logic [3:0]  ch_q, ch_d;
  logic [7:0]  rdata_d;
  logic        adc_tick, start_evt, last_ch, conv_end;
  logic [9:0]  dec_rate;
  logic [11:0] res_mask;

  assign bus = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
  assign adc_tick = (div_q == `ACR_ADC_DIV - 3'h1);

  // RULE10 thirteen steps per request
  // Fully unrolled, so one request costs one cycle
  logic [15:0] lfsr_stage [0:`ACR_LFSR_UNROLL];
  assign lfsr_stage[0] = lfsr_q;
  for (genvar s = 0; s < `ACR_LFSR_UNROLL; s++)
  begin : g_lfsr_step
    assign lfsr_stage[s + 1] = lfsr_stage[s][15] ?
      ((lfsr_stage[s] << 1) ^ `ACR_LFSR_TAPS) : (lfsr_stage[s] << 1);
  end

  // RULE15 rates and widths
  // RULE16 upper codes
  always_comb
  begin
    unique case (dec_q)
      2'h0:
      begin
        dec_rate = 10'h040;
        res_mask = 12'hFE0;
      end
      2'h1:
      begin
        dec_rate = 10'h080;
        res_mask = 12'hFF8;
      end
      2'h2:
      begin
        dec_rate = 10'h100;
        res_mask = 12'hFFC;
      end
      2'h3:
      begin
        dec_rate = 10'h200;
        res_mask = 12'hFFF;
      end
    endcase
  end

  // RULE8 trigger selection
  // RULE19 pin rising edge
  // RULE9 full speed restart
  always_comb
  begin
    unique case (acr_pkg::acr_trig_e'(trig_q))
      acr_pkg::ACR_TRIG_EXT:   start_evt = external_trigger_pin & ~pin_q;
      acr_pkg::ACR_TRIG_FULL:  start_evt = 1'b1;
      acr_pkg::ACR_TRIG_TIMER: start_evt = timer_compare_evt;
      acr_pkg::ACR_TRIG_GO:    start_evt = go_q;
    endcase
  end

  // RULE17 sequence endpoint, single conversions for high codes
  assign last_ch  = (sequence_end_field >= 4'hC) ||
                    (ch_q == sequence_end_field);
  assign conv_end = (st_q == acr_pkg::ACR_DECIM) && adc_tick &&
                    (cnt_q == dec_rate - 10'h001);

  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    ch_d  = ch_q;
    res_d = res_q;
    div_d = adc_tick ? 3'h0 : div_q + 3'h1;
    unique case (st_q)
      acr_pkg::ACR_IDLE:
        if (start_evt)
        begin
          st_d  = acr_pkg::ACR_SETTLE;
          cnt_d = 10'h000;
          div_d = 3'h0;
          // RULE17 first pair
          ch_d  = (sequence_end_field >= 4'hC) ? sequence_end_field :
                  {sequence_end_field[3], 3'h0};
        end
      // RULE18 settle sixteen then decimate
      acr_pkg::ACR_SETTLE:
        if (adc_tick)
        begin
          cnt_d = cnt_q + 10'h001;
          if (cnt_q == `ACR_SETTLE_CLKS - 10'h001)
          begin
            st_d  = acr_pkg::ACR_DECIM;
            cnt_d = 10'h000;
          end
        end
      acr_pkg::ACR_DECIM:
        if (adc_tick)
        begin
          cnt_d = cnt_q + 10'h001;
          if (conv_end)
          begin
            // RULE3 masked resolution
            // RULE14 rate sets width
            res_d = modulator_sample & res_mask;
            cnt_d = 10'h000;
            if (last_ch)
              st_d = acr_pkg::ACR_IDLE;
            else
            begin
              st_d = acr_pkg::ACR_SETTLE;
              ch_d = ch_q + 4'h1;
            end
          end
        end
      // Unused code 10 falls back to idle
      default:
        st_d = acr_pkg::ACR_IDLE;
    endcase
  end

  always_comb
  begin
    trig_d = trig_q;
    rnd_d  = rnd_q;
    low_d  = low_q;
    ref_d  = ref_q;
    dec_d  = dec_q;
    go_d   = go_q;
    lfsr_d = lfsr_q;
    // RULE4 set on end, clear on high read
    // RULE5 set wins, no overrun
    // A result landing on the high read stays flagged
    done_d = conv_end | (done_q &
             ~(bus.rd && bus.addr == `ACR_OFF_RES_HIGH));
    // RULE6 clears at sequence end
    if (conv_end && last_ch)
      go_d = 1'b0;
    // RULE10 thirteen unrolled steps
    // RULE11 field self clears
    if (rnd_q == 2'h1)
    begin
      lfsr_d = lfsr_stage[`ACR_LFSR_UNROLL];
      rnd_d  = 2'h0;
    end
    if (bus.wr && bus.addr == `ACR_OFF_CTRL_ONE)
    begin
      // RULE7 go only with source 11 and idle
      // RULE20 zero write ignored
      if (bus.wdata[`ACR_C1_GO_BIT] && st_q == acr_pkg::ACR_IDLE &&
          bus.wdata[`ACR_C1_TRIG_HI:`ACR_C1_TRIG_LO] == 2'h3)
        go_d = 1'b1;
      trig_d = bus.wdata[`ACR_C1_TRIG_HI:`ACR_C1_TRIG_LO];
      rnd_d  = bus.wdata[`ACR_C1_RND_HI:`ACR_C1_RND_LO];
      // RULE12 stored as written, software keeps 11
      low_d  = bus.wdata[1:0];
    end
    if (bus.wr && bus.addr == `ACR_OFF_CTRL_TWO)
    begin
      // RULE13 reference choice
      ref_d = bus.wdata[`ACR_C2_REF_HI:`ACR_C2_REF_LO];
      dec_d = bus.wdata[`ACR_C2_DEC_HI:`ACR_C2_DEC_LO];
    end
  end

  always_comb
  begin
    rdata_d = 8'h00;
    if (bus.rd)
    begin
      unique case (bus.addr)
        `ACR_OFF_CTRL_ONE: rdata_d = {done_q, go_q, trig_q, rnd_q, low_q};
        `ACR_OFF_CTRL_TWO: rdata_d = {ref_q, dec_q, ch_q};
        // RULE1 low nibble zero
        `ACR_OFF_RES_LOW:  rdata_d = {res_q[3:0], 4'h0};
        // RULE2 high byte
        `ACR_OFF_RES_HIGH: rdata_d = res_q[11:4];
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  // Sequencer state and its registered outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q        <= acr_pkg::ACR_IDLE;
      pin_q       <= 1'b0;
      res_q       <= 12'h000;
      div_q       <= 3'h0;
      cnt_q       <= 10'h000;
      ch_q        <= 4'h0;
      mux_channel <= 4'h0;
      conv_active <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      pin_q       <= external_trigger_pin;
      res_q       <= res_d;
      div_q       <= div_d;
      cnt_q       <= cnt_d;
      ch_q        <= ch_d;
      mux_channel <= ch_d;
      conv_active <= (st_d != acr_pkg::ACR_IDLE);
    end
  end

  // Software visible control state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_q                 <= `ACR_RST_TRIG;
      rnd_q                  <= 2'h0;
      low_q                  <= `ACR_RST_RES_LOW;
      ref_q                  <= 2'h0;
      dec_q                  <= `ACR_RST_DEC;
      done_q                 <= 1'b0;
      go_q                   <= 1'b0;
      lfsr_q                 <= `ACR_RST_LFSR;
      reference_choice_field <= 2'h0;
      random_value           <= `ACR_RST_LFSR;
    end
    else
    begin
      trig_q                 <= trig_d;
      rnd_q                  <= rnd_d;
      low_q                  <= low_d;
      ref_q                  <= ref_d;
      dec_q                  <= dec_d;
      done_q                 <= done_d;
      go_q                   <= go_d;
      lfsr_q                 <= lfsr_d;
      reference_choice_field <= ref_d;
      random_value           <= lfsr_d;
    end
  end

  // Read port, data stands one cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= rdata_d;
    end
  end
endmodule // acr_ctrl

/* rtl/acr_params.svh */
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
// Register offsets
`define ACR_OFF_CTRL_ONE 8'hB4
`define ACR_OFF_CTRL_TWO 8'hB5
`define ACR_OFF_RES_LOW  8'hBA
`define ACR_OFF_RES_HIGH 8'hBB
// Control one field positions
`define ACR_C1_DONE_BIT  7
`define ACR_C1_GO_BIT    6
`define ACR_C1_TRIG_HI   5
`define ACR_C1_TRIG_LO   4
`define ACR_C1_RND_HI    3
`define ACR_C1_RND_LO    2
// Control two field positions
`define ACR_C2_REF_HI    7
`define ACR_C2_REF_LO    6
`define ACR_C2_DEC_HI    5
`define ACR_C2_DEC_LO    4
// Reset values
`define ACR_RST_TRIG     2'h3
`define ACR_RST_RES_LOW  2'h3
`define ACR_RST_DEC      2'h1
`define ACR_RST_LFSR     16'hACE1
// Timing, ADC clock is mclk divided by six
`define ACR_ADC_DIV      3'h6
`define ACR_SETTLE_CLKS  10'h010
`define ACR_LFSR_UNROLL  13
`define ACR_LFSR_TAPS    16'h8005
`endif

/* rtl/acr_pkg.sv */
package acr_pkg;
  typedef enum logic [1:0] {
    ACR_TRIG_EXT   = 2'h0,
    ACR_TRIG_FULL  = 2'h1,
    ACR_TRIG_TIMER = 2'h2,
    ACR_TRIG_GO    = 2'h3
  } acr_trig_e;
  typedef enum logic [1:0] {
    ACR_IDLE   = 2'h0,
    ACR_SETTLE = 2'h1,
    ACR_DECIM  = 2'h3
  } acr_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acr_bus_s;
endpackage
